// ==== hw/rko_driver.sv ====
// remote key output driver: learned key events to four outputs, straps, led, apb
// Behaviour
// [R1] The pair A select governs outputs one and two, the pair B select outputs three and four.
// [R2] With a pair select high, each output of the pair toggles once per key press assigned to it.
// [R3] With a pair select low, each output of the pair is high only while its key is held.
// [R4] An output moves only for a learned remote and key associated with that output.
// [R5] In add/remove or erase, the two pair selects pick which output is programmed.
// [R6] In add/remove or erase, the global select enables the global learning feature.
// [R7] The erase select asks for erase on its own, whatever the add/remove select does.
// [R8] With both add/remove and erase selects high the block stays in normal operation.
// [R9] A low on the reset pin lasting at least two microseconds resets the block.
// [R10] The block resets itself at power-up with the reset pin left open.
// [R11] The led output is driven while learning so a light can guide the user.
// [R12] Every received key is reported on the report port while the outputs also update.
// [R13] Learning can be entered from the strap inputs or from the software interface.
// [R14] Pair selects are sampled anew on every received frame.
// [R15] The association store holds up to eighteen remotes.
// [R16] A held key counts as released once no repeat frame arrives within the hold timeout.
// [R17] After any reset all four outputs and the led are low.
//
// Decided for this implementation: the placing of the registers and the APB register port.
module rko_driver
  import rko_pkg::*;
#(
  parameter logic [23:0] HOLD_LEN = rko_pkg::HOLD_CYCLES
) (
  // clock and reset
  input  wire logic                   REF_CLK,
  input  wire logic                   RST,
  input  wire logic                   CE,
  // strap and reset pins
  input  wire rko_pkg::rko_straps_t   STRAPS,
  // decoded radio key events
  input  wire rko_pkg::rko_event_t    KEY_EVENT,
  // serial side report
  output rko_pkg::rko_report_t        REPORT,
  // pins to loads
  output logic                        KEY_OUTPUT_1,
  output logic                        KEY_OUTPUT_2,
  output logic                        KEY_OUTPUT_3,
  output logic                        KEY_OUTPUT_4,
  output logic                        LEARN_LED,
  // apb slave
  input  wire rko_pkg::rko_apb_req_t  APB_REQ,
  output rko_pkg::rko_apb_rsp_t       APB_RSP
);

  import rko_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic rko_state_t reset_state();
    rko_state_t r;
    r      = '0;
    r.s1   = STRAPS_IDLE;
    r.s2   = STRAPS_IDLE;
    r.s3   = STRAPS_IDLE;
    r.pins = STRAPS_IDLE;
    r.mode = MODE_NORMAL;
    return r;
  endfunction

  localparam rko_state_t ST_RESET = reset_state();

  function automatic logic [3:0] map_bit(input logic [1:0] key, input logic [1:0] out);
    map_bit = {key, out};
  endfunction

  // pair A serves outputs one and two, pair B outputs three and four
  function automatic logic pair_select(input rko_straps_t p, input int o);
    if (o < 2) begin
      return p.pair_a_behaviour_select; // R1
    end
    return p.pair_b_behaviour_select; // R1
  endfunction

  // erase outranks add so a stuck add switch cannot block an erase
  function automatic rko_mode_t pick_mode(input logic erase, input logic add);
    if (erase) begin
      return MODE_ERASE;
    end else if (add) begin
      return MODE_ADD;
    end
    return MODE_NORMAL;
  endfunction

  // first matching slot (want_free=0) or first empty slot (want_free=1)
  function automatic logic [IDX_W:0] find_slot(input rko_entry_t [NUM_REMOTES-1:0] s,
                                               input logic [SERIAL_W-1:0]          serial,
                                               input logic                         want_free);
    logic [IDX_W:0] r;
    r = '0;
    for (int i = NUM_REMOTES - 1; i >= 0; i--) begin
      if (want_free ? !s[i].valid : (s[i].valid && s[i].serial == serial)) begin
        r = {1'b1, IDX_W'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic reg_ok(input logic [7:0] addr, input logic [IDX_W-1:0] idx);
    case (addr)
      ADDR_CTRL, ADDR_STATUS, ADDR_ENTRY_SEL, ADDR_LAST_FRAME: reg_ok = 1'b1;
      ADDR_ENTRY_SERIAL, ADDR_ENTRY_MAP: reg_ok = (32'(idx) < NUM_REMOTES);
      default: reg_ok = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rko_state_t          st;
  rko_state_t          nx;
  rko_entry_t          work;
  logic [IDX_W:0]      match;
  logic [IDX_W:0]      free;
  logic                strap_learn;
  logic                want_add;
  logic                want_erase;
  logic [1:0]          out_sel;
  logic                glob;
  logic                newv;
  logic                pair_flop;
  logic [3:0]          bit_idx;
  logic [31:0]         rdata;
  logic                access;
  rko_state_t          keep;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nx          = st;
    work        = '0;
    keep        = st;
    newv        = 1'b0;
    pair_flop   = 1'b0;
    bit_idx     = '0;
    rdata       = '0;
    nx.rep.valid = 1'b0;

    // pin synchroniser; a level counts once stages two and three agree
    nx.s1 = STRAPS;
    nx.s2 = st.s1;
    nx.s3 = st.s2;
    if (st.s2 == st.s3) begin
      nx.pins = st.s3;
    end

    // hold timers: expiry releases a monostable output
    for (int o = 0; o < NUM_OUTPUTS; o++) begin
      if (st.hold[o] != '0) begin
        nx.hold[o] = st.hold[o] - HOLD_ONE;
        if (st.hold[o] == HOLD_ONE && st.mono[o]) begin
          nx.dout[o] = 1'b0; // R16 R3
        end
      end
    end
    if (st.learn_hold != '0) begin
      nx.learn_hold = st.learn_hold - HOLD_ONE;
    end

    // learning mode selection
    strap_learn = !st.pins.add_remove_n || !st.pins.erase_n; // R8
    want_erase  = !st.pins.erase_n || st.ctrl[CTRL_ERASE]; // R7 R13
    want_add    = !st.pins.add_remove_n || st.ctrl[CTRL_LEARN]; // R13
    // straps outrank software for the output and global selects when both ask for learning
    out_sel = strap_learn ? {st.pins.pair_b_behaviour_select, st.pins.pair_a_behaviour_select}
                          : st.ctrl[CTRL_OUT_LSB +: 2]; // R5
    glob    = strap_learn ? st.pins.global_sel : st.ctrl[CTRL_GLOBAL]; // R6
    nx.mode = pick_mode(want_erase, want_add); // R7 R8
    nx.led = (nx.mode != MODE_NORMAL); // R11

    // erase acts once, on entry
    if (nx.mode == MODE_ERASE && st.mode != MODE_ERASE) begin
      for (int i = 0; i < NUM_REMOTES; i++) begin
        if (glob) begin
          nx.store[i].valid = 1'b0; // R6
        end else begin
          for (int k = 0; k < NUM_KEYS; k++) begin
            nx.store[i].map[map_bit(2'(k), out_sel)] = 1'b0; // R5
          end
          if ((nx.store[i].map) == '0) begin
            nx.store[i].valid = 1'b0;
          end
        end
      end
    end

    // ----------------------------------------------------------------
    // received key frames
    // ----------------------------------------------------------------
    match = find_slot(st.store, KEY_EVENT.serial, 1'b0);
    free  = find_slot(st.store, KEY_EVENT.serial, 1'b1);
    if (KEY_EVENT.valid) begin
      // every frame is reported, learned or not
      nx.rep.valid  = 1'b1; // R12
      nx.rep.serial = KEY_EVENT.serial;
      nx.rep.key    = KEY_EVENT.key;
      nx.rep.known  = match[IDX_W];
      case (st.mode)
        MODE_NORMAL: begin
          if (match[IDX_W]) begin
            work = st.store[match[IDX_W-1:0]];
            for (int o = 0; o < NUM_OUTPUTS; o++) begin
              pair_flop = pair_select(st.pins, o); // R1 R14
              if (work.map[map_bit(KEY_EVENT.key, 2'(o))]) begin // R4
                if (!pair_flop) begin
                  nx.dout[o] = 1'b1; // R3
                end else if (st.hold[o] == '0) begin
                  nx.dout[o] = !st.dout[o]; // R2
                end
                // a repeat frame while held is not a new press
                nx.hold[o] = HOLD_LEN; // R16
                nx.mono[o] = !pair_flop;
              end
            end
          end
        end
        MODE_ADD: begin
          nx.learn_hold = HOLD_LEN;
          if (st.learn_hold == '0) begin
            bit_idx = map_bit(KEY_EVENT.key, out_sel);
            if (match[IDX_W]) begin
              work = st.store[match[IDX_W-1:0]];
            end else begin
              work.serial = KEY_EVENT.serial;
            end
            newv = !work.map[bit_idx];
            if (glob) begin
              for (int k = 0; k < NUM_KEYS; k++) begin
                work.map[map_bit(2'(k), out_sel)] = newv; // R6
              end
            end else begin
              work.map[bit_idx] = newv; // R5
            end
            work.valid = (work.map != '0);
            if (match[IDX_W]) begin
              nx.store[match[IDX_W-1:0]] = work;
            end else if (free[IDX_W]) begin
              nx.store[free[IDX_W-1:0]] = work; // R15
            end
          end
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // apb slave: one wait state, write lands on the completing edge
    // ----------------------------------------------------------------
    case (APB_REQ.paddr)
      ADDR_CTRL:         rdata = 32'(st.ctrl);
      ADDR_STATUS:       rdata = 32'({st.mode, st.led, st.dout});
      ADDR_ENTRY_SEL:    rdata = 32'(st.sel_idx);
      ADDR_ENTRY_SERIAL: begin
        if (reg_ok(APB_REQ.paddr, st.sel_idx)) begin
          rdata[ENTRY_VALID_BIT]  = st.store[st.sel_idx].valid;
          rdata[SERIAL_W-1:0]     = st.store[st.sel_idx].serial;
        end
      end
      ADDR_ENTRY_MAP: begin
        if (reg_ok(APB_REQ.paddr, st.sel_idx)) begin
          rdata[MAP_W-1:0] = st.store[st.sel_idx].map;
        end
      end
      ADDR_LAST_FRAME: begin
        rdata[LAST_HIT_BIT]            = st.rep.known;
        rdata[LAST_KEY_LSB +: 2]       = st.rep.key;
        rdata[SERIAL_W-1:0]            = st.rep.serial;
      end
      default: rdata = '0;
    endcase

    access = APB_REQ.psel && APB_REQ.penable;
    if (access && !st.rsp.pready) begin
      nx.rsp.pready  = 1'b1;
      nx.rsp.pslverr = !reg_ok(APB_REQ.paddr, st.sel_idx);
      nx.rsp.prdata  = rdata;
    end else begin
      nx.rsp.pready  = 1'b0;
      nx.rsp.pslverr = 1'b0;
      // software writes win over a same-cycle frame update
      if (access && APB_REQ.pwrite && reg_ok(APB_REQ.paddr, st.sel_idx)) begin
        case (APB_REQ.paddr)
          ADDR_CTRL:      nx.ctrl    = APB_REQ.pwdata[CTRL_W-1:0]; // R13
          ADDR_ENTRY_SEL: nx.sel_idx = APB_REQ.pwdata[IDX_W-1:0];
          ADDR_ENTRY_SERIAL: begin
            nx.store[st.sel_idx].valid  = APB_REQ.pwdata[ENTRY_VALID_BIT];
            nx.store[st.sel_idx].serial = APB_REQ.pwdata[SERIAL_W-1:0];
          end
          ADDR_ENTRY_MAP: nx.store[st.sel_idx].map = APB_REQ.pwdata[MAP_W-1:0];
          default: begin
          end
        endcase
      end
    end

    // ----------------------------------------------------------------
    // reset pin: filtered low long enough resets all but the store, the pin synchroniser and its counter
    // ----------------------------------------------------------------
    if (!st.pins.reset_n) begin
      if (st.rst_cnt != EXT_RST_CYCLES) begin
        nx.rst_cnt = st.rst_cnt + 8'h01;
      end
    end else begin
      nx.rst_cnt = '0;
    end
    if (!st.pins.reset_n && nx.rst_cnt == EXT_RST_CYCLES) begin
      keep       = nx;
      nx         = ST_RESET; // R9 R17
      nx.store   = keep.store;
      nx.s1      = keep.s1;
      nx.s2      = keep.s2;
      nx.s3      = keep.s3;
      nx.pins    = keep.pins;
      nx.rst_cnt = keep.rst_cnt;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      st <= ST_RESET; // R10 R17
    end else if (CE) begin
      st <= nx;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from state
  // ----------------------------------------------------------------
  assign KEY_OUTPUT_1 = st.dout[0];
  assign KEY_OUTPUT_2 = st.dout[1];
  assign KEY_OUTPUT_3 = st.dout[2];
  assign KEY_OUTPUT_4 = st.dout[3];
  assign LEARN_LED    = st.led;
  assign REPORT       = st.rep;
  assign APB_RSP      = st.rsp;

endmodule // rko_driver

// ==== hw/rko_pkg.sv ====
// constants, carriers and state type of the remote key output driver
package rko_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_REMOTES = 18;
  localparam int NUM_OUTPUTS = 4;
  localparam int NUM_KEYS    = 4;
  localparam int SERIAL_W    = 24;
  localparam int IDX_W       = 5;
  localparam int HOLD_W      = 24;
  localparam int MAP_W       = NUM_KEYS * NUM_OUTPUTS;
  localparam int CTRL_W      = 5;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 10;
  localparam int EXT_RST_MIN_NS   = 2000;
  localparam int EXT_RST_CYCLES_I = (EXT_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] EXT_RST_CYCLES = 8'(EXT_RST_CYCLES_I);
  localparam int HOLD_TIME_MS  = 120;
  localparam int HOLD_CYCLES_I = HOLD_TIME_MS * (1000000 / CLK_PERIOD_NS);
  localparam logic [HOLD_W-1:0] HOLD_CYCLES = HOLD_W'(HOLD_CYCLES_I);
  localparam logic [HOLD_W-1:0] HOLD_ONE    = 24'h000001;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL         = 8'h00;
  localparam logic [7:0] ADDR_STATUS       = 8'h04;
  localparam logic [7:0] ADDR_ENTRY_SEL    = 8'h08;
  localparam logic [7:0] ADDR_ENTRY_SERIAL = 8'h0C;
  localparam logic [7:0] ADDR_ENTRY_MAP    = 8'h10;
  localparam logic [7:0] ADDR_LAST_FRAME   = 8'h14;

  localparam int CTRL_LEARN      = 0;
  localparam int CTRL_ERASE      = 1;
  localparam int CTRL_OUT_LSB    = 2;
  localparam int CTRL_GLOBAL     = 4;
  localparam int STAT_LED_BIT    = 4;
  localparam int STAT_MODE_LSB   = 5;
  localparam int ENTRY_VALID_BIT = 31;
  localparam int LAST_KEY_LSB    = 24;
  localparam int LAST_HIT_BIT    = 31;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_ADD    = 2'b01,
    MODE_ERASE  = 2'b10
  } rko_mode_t;

  typedef struct packed {
    logic reset_n;
    logic add_remove_n;
    logic erase_n;
    logic global_sel;
    logic pair_b_behaviour_select;
    logic pair_a_behaviour_select;
  } rko_straps_t;

  localparam rko_straps_t STRAPS_IDLE = '{reset_n: 1'b1, add_remove_n: 1'b1,
                                          erase_n: 1'b1, default: 1'b0};

  typedef struct packed {
    logic                valid;
    logic [SERIAL_W-1:0] serial;
    logic [1:0]          key;
  } rko_event_t;

  typedef struct packed {
    logic                valid;
    logic [SERIAL_W-1:0] serial;
    logic [1:0]          key;
    logic                known;
  } rko_report_t;

  typedef struct packed {
    logic                valid;
    logic [SERIAL_W-1:0] serial;
    logic [MAP_W-1:0]    map;
  } rko_entry_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } rko_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rko_apb_rsp_t;

  typedef struct packed {
    rko_straps_t                         s1;
    rko_straps_t                         s2;
    rko_straps_t                         s3;
    rko_straps_t                         pins;
    logic [7:0]                          rst_cnt;
    rko_mode_t                           mode;
    logic [NUM_OUTPUTS-1:0]              dout;
    logic [NUM_OUTPUTS-1:0]              mono;
    logic [NUM_OUTPUTS-1:0][HOLD_W-1:0]  hold;
    logic [HOLD_W-1:0]                   learn_hold;
    rko_entry_t [NUM_REMOTES-1:0]        store;
    logic                                led;
    logic [CTRL_W-1:0]                   ctrl;
    logic [IDX_W-1:0]                    sel_idx;
    rko_report_t                         rep;
    rko_apb_rsp_t                        rsp;
  } rko_state_t;

endpackage : rko_pkg

// ==== tb/rko_driver_assertions.sv ====
// port checks of the remote key output driver
module rko_driver_checker
  import rko_pkg::*;
#(
  parameter logic [23:0] HOLD_LEN = rko_pkg::HOLD_CYCLES
) (
  // clock and reset
  input wire logic                  REF_CLK,
  input wire logic                  RST,
  input wire logic                  CE,
  // events and pins
  input wire rko_pkg::rko_straps_t  STRAPS,
  input wire rko_pkg::rko_event_t   KEY_EVENT,
  input wire rko_pkg::rko_report_t  REPORT,
  input wire logic                  KEY_OUTPUT_1,
  input wire logic                  KEY_OUTPUT_2,
  input wire logic                  KEY_OUTPUT_3,
  input wire logic                  KEY_OUTPUT_4,
  input wire logic                  LEARN_LED,
  // apb
  input wire rko_pkg::rko_apb_req_t APB_REQ,
  input wire rko_pkg::rko_apb_rsp_t APB_RSP
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]  outs;
  logic [23:0] since;
  assign outs = {KEY_OUTPUT_4, KEY_OUTPUT_3, KEY_OUTPUT_2, KEY_OUTPUT_1};
  // ----
  // cycles since last frame, saturating so a long idle never wraps
  // ----
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      since <= 24'h000000;
    end else if (CE && KEY_EVENT.valid) begin
      since <= 24'h000000;
    end else if (CE && since != 24'hFFFFFF) begin
      since <= since + 24'h000001;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  report_next_a: assert property (KEY_EVENT.valid && CE |=> REPORT.valid)
    else $error("report missing after frame");
  report_cause_a: assert property (REPORT.valid |-> $past(KEY_EVENT.valid))
    else $error("report without frame");
  report_data_a: assert property (REPORT.valid |->
    REPORT.serial == $past(KEY_EVENT.serial) && REPORT.key == $past(KEY_EVENT.key))
    else $error("report carries wrong frame");
  out_rise_a: assert property (|(outs & ~$past(outs)) |-> $past(KEY_EVENT.valid))
    else $error("output rose without frame");
  mono_release_a: assert property (|(~outs & $past(outs)) && !$past(KEY_EVENT.valid)
    && STRAPS.reset_n |-> since >= HOLD_LEN - 24'h000001 && since <= HOLD_LEN + 24'h000003)
    else $error("output fell off the hold timeout");
  reset_clear_a: assert property (disable iff (1'b0)
    $fell(RST) |-> outs == 4'h0 && !LEARN_LED && !APB_RSP.pready)
    else $error("outputs not cleared by reset");
  apb_wait_a: assert property (APB_REQ.psel && APB_REQ.penable && !APB_RSP.pready
    |=> APB_RSP.pready)
    else $error("apb answer not after one wait state");
  apb_cause_a: assert property ($rose(APB_RSP.pready) |->
    $past(APB_REQ.psel && APB_REQ.penable))
    else $error("apb answer without access");
  cover property ($rose(KEY_OUTPUT_1));
  cover property ($rose(LEARN_LED));
  cover property (APB_RSP.pslverr);
endmodule // rko_driver_checker

bind rko_driver rko_driver_checker #(.HOLD_LEN(HOLD_LEN)) u_chk (
  .REF_CLK(REF_CLK), .RST(RST), .CE(CE), .STRAPS(STRAPS), .KEY_EVENT(KEY_EVENT),
  .REPORT(REPORT), .KEY_OUTPUT_1(KEY_OUTPUT_1), .KEY_OUTPUT_2(KEY_OUTPUT_2),
  .KEY_OUTPUT_3(KEY_OUTPUT_3), .KEY_OUTPUT_4(KEY_OUTPUT_4), .LEARN_LED(LEARN_LED),
  .APB_REQ(APB_REQ), .APB_RSP(APB_RSP));

// ==== tb/rko_driver_tb.sv ====
// self-checking bench of the remote key output driver
module rko_driver_tb;
  import rko_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // short hold keeps the run brief
  localparam logic [23:0] HOLD = 24'h000032;
  localparam logic [23:0] SER  = 24'h5A1C3E;
  logic         clk;
  logic         rst;
  logic         ce;
  logic         add_sw;
  logic         erase_sw;
  logic         reset_sw;
  logic         glob;
  logic         sel_a;
  logic         sel_b;
  rko_event_t   ev;
  rko_apb_req_t req;
  rko_apb_rsp_t rsp;
  rko_report_t  rep;
  rko_straps_t  straps;
  logic [3:0]   dout;
  logic         led;
  logic [31:0]  rd_q;
  logic         rd_err;
  int           n_fail;
  int           comparisons;
  rko_strap_bank u_bank (.ADD_SW(add_sw), .ERASE_SW(erase_sw), .RESET_SW(reset_sw),
    .GLOBAL_J(glob), .SEL_A_J(sel_a), .SEL_B_J(sel_b), .STRAPS(straps));
  rko_driver #(.HOLD_LEN(HOLD)) dut (.REF_CLK(clk), .RST(rst), .CE(ce), .STRAPS(straps),
    .KEY_EVENT(ev), .REPORT(rep), .KEY_OUTPUT_1(dout[0]), .KEY_OUTPUT_2(dout[1]),
    .KEY_OUTPUT_3(dout[2]), .KEY_OUTPUT_4(dout[3]), .LEARN_LED(led), .APB_REQ(req),
    .APB_RSP(rsp));
  // ----
  // shared tasks
  // ----
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n == 20) begin
      n_fail++;
      final_report();
    end
    rd_q = rsp.prdata;
    rd_err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic key_ev(input logic [23:0] s, input logic [1:0] k, input logic kn);
    @(posedge clk);
    ev <= '{valid: 1'b1, serial: s, key: k};
    @(posedge clk);
    ev.valid <= 1'b0;
    @(negedge clk);
    chk(32'({rep.valid, rep.known, rep.key, rep.serial}), 32'({1'b1, kn, k, s}));
  endtask
  task automatic wait_led(input logic e);
    int n;
    n = 0;
    while (led !== e && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n == 40) begin
      n_fail++;
      final_report();
    end
    chk(32'(led), 32'(e));
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    chk(32'({led, dout}), 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd_q, 32'h0);
  endtask
  task automatic t_store();
    apb(1'b1, ADDR_ENTRY_SEL, 32'h12);
    apb(1'b0, ADDR_ENTRY_SERIAL, 32'h0);
    chk(32'(rd_err), 32'h1);
    apb(1'b1, ADDR_ENTRY_SEL, 32'h11);
    apb(1'b0, ADDR_ENTRY_SERIAL, 32'h0);
    chk({rd_err, rd_q[30:0]}, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(rd_err), 32'h1);
    apb(1'b1, ADDR_ENTRY_SEL, 32'h0);
    apb(1'b1, ADDR_ENTRY_SERIAL, {8'h80, SER});
    apb(1'b1, ADDR_ENTRY_MAP, 32'h00008421);
    apb(1'b0, ADDR_ENTRY_MAP, 32'h0);
    chk(rd_q, 32'h00008421);
  endtask
  task automatic t_toggle();
    key_ev(SER, 2'h0, 1'b1);
    chk(32'(dout), 32'h1);
    key_ev(SER, 2'h0, 1'b1);
    chk(32'(dout), 32'h1);
    cycles(int'(HOLD) + 10);
    key_ev(SER, 2'h0, 1'b1);
    chk(32'(dout), 32'h0);
    key_ev(SER, 2'h1, 1'b1);
    cycles(int'(HOLD) + 10);
    chk(32'(dout), 32'h2);
    // a frame while the enable is low must be lost
    @(posedge clk);
    ce <= 1'b0;
    @(posedge clk);
    ev <= '{valid: 1'b1, serial: SER, key: 2'h0};
    @(posedge clk);
    ev.valid <= 1'b0;
    cycles(3);
    chk(32'({rep.valid, dout}), 32'h2);
    @(posedge clk);
    ce <= 1'b1;
  endtask
  task automatic t_mono();
    key_ev(SER, 2'h2, 1'b1);
    chk(32'(dout), 32'h6);
    cycles(20);
    key_ev(SER, 2'h2, 1'b1);
    cycles(int'(HOLD) - 5);
    chk(32'(dout), 32'h6);
    cycles(10);
    chk(32'(dout), 32'h2);
    key_ev(24'h00BEEF, 2'h0, 1'b0);
    chk(32'(dout), 32'h2);
    @(posedge clk);
    sel_b <= 1'b1;
    cycles(8);
    key_ev(SER, 2'h3, 1'b1);
    cycles(int'(HOLD) + 10);
    chk(32'(dout), 32'hA);
    apb(1'b0, ADDR_LAST_FRAME, 32'h0);
    chk(rd_q, {1'b1, 5'h00, 2'h3, SER});
  endtask
  task automatic t_learn();
    @(posedge clk);
    add_sw <= 1'b1;
    wait_led(1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(rd_q[6:5]), 32'h1);
    @(posedge clk);
    add_sw <= 1'b0;
    wait_led(1'b0);
    @(posedge clk);
    erase_sw <= 1'b1;
    wait_led(1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(rd_q[6:5]), 32'h2);
    @(posedge clk);
    erase_sw <= 1'b0;
    wait_led(1'b0);
    apb(1'b1, ADDR_CTRL, 32'h1);
    wait_led(1'b1);
    key_ev(24'h00BEEF, 2'h2, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0);
    wait_led(1'b0);
    chk(32'(dout), 32'hA);
    apb(1'b1, ADDR_ENTRY_SEL, 32'h1);
    apb(1'b0, ADDR_ENTRY_MAP, 32'h0);
    chk(rd_q, 32'h00000100);
  endtask
  task automatic t_pin_reset();
    @(posedge clk);
    reset_sw <= 1'b1;
    cycles(100);
    @(posedge clk);
    reset_sw <= 1'b0;
    cycles(8);
    chk(32'(dout), 32'hA);
    @(posedge clk);
    reset_sw <= 1'b1;
    cycles(210);
    chk(32'({led, dout}), 32'h0);
    @(posedge clk);
    reset_sw <= 1'b0;
    cycles(8);
    apb(1'b0, ADDR_ENTRY_SERIAL, 32'h0);
    chk(rd_q, {8'h80, SER});
    @(posedge clk);
    glob <= 1'b1;
    erase_sw <= 1'b1;
    wait_led(1'b1);
    @(posedge clk);
    erase_sw <= 1'b0;
    wait_led(1'b0);
    apb(1'b0, ADDR_ENTRY_SERIAL, 32'h0);
    chk(32'(rd_q[31]), 32'h0);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    {add_sw, erase_sw, reset_sw, glob, sel_b} = 5'h00;
    sel_a = 1'b1;
    ev = '0;
    req = '0;
    n_fail = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    cycles(8);
    t_reset();
    t_store();
    t_toggle();
    t_mono();
    t_learn();
    t_pin_reset();
    final_report();
  end
endmodule // rko_driver_tb

// ==== tb/rko_strap_bank.sv ====
// switch and jumper bank with pull-ups beside the receiver
module rko_strap_bank
  import rko_pkg::*;
(
  // switches, high = closed to ground
  input  wire logic            ADD_SW,
  input  wire logic            ERASE_SW,
  input  wire logic            RESET_SW,
  // jumper levels
  input  wire logic            GLOBAL_J,
  input  wire logic            SEL_A_J,
  input  wire logic            SEL_B_J,
  // to the receiver
  output rko_pkg::rko_straps_t STRAPS
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    STRAPS = STRAPS_IDLE;
    // open switches float to the pull-up: normal operation
    STRAPS.add_remove_n = !ADD_SW;
    STRAPS.erase_n = !ERASE_SW;
    // an open reset line idles high; the pulse length is the bench's job
    STRAPS.reset_n = !RESET_SW;
    STRAPS.global_sel = GLOBAL_J;
    STRAPS.pair_a_behaviour_select = SEL_A_J;
    STRAPS.pair_b_behaviour_select = SEL_B_J;
  end
endmodule // rko_strap_bank
